// *** logic/bpo_consts.svh ***
/*
 Constants of the bridge port option and timeout block: offsets, field
 positions, writable masks and reset values.
 Assumes inclusion by bare name from the top module and the testbench.
*/
// What this block does
// - Bit 4 aliases MWI retry to MW
// - Bit 7: primary MWI converted or line-disconnected
// - Bit 8: secondary MWI converted or line-disconnected
// - Bit 9 selects long request locks, reset 0
// - Bit 10 secondary request hold policy, reset 1
// - Bit 11 primary request hold policy, reset 1
// - Reserved option bits read zero, ignore writes
// - Retry attempt limit, reset 2 to 24
// - Primary master timeout, reset 8000h
// - Secondary master timeout, upper half, reset 8000h
// - Undelivered posted write sets bit 18, error
// - Unrepeated delayed transaction sets bit 23, error
`ifndef BPO_CONSTS_SVH
`define BPO_CONSTS_SVH
// ==========================================================
// Register offsets
`define BPO_OFF_STATUS 8'h68
`define BPO_OFF_OPTION 8'h74
`define BPO_OFF_RETRY 8'h78
`define BPO_OFF_TIMEOUT 8'h80
`define BPO_OFF_MASK 8'h84
// ==========================================================
// Option fields
`define BPO_OPT_SEC_MW_ALIAS 4
`define BPO_OPT_PRI_MWI_DISC 7
`define BPO_OPT_SEC_MWI_DISC 8
`define BPO_OPT_LOCK_LONG 9
`define BPO_OPT_SEC_HOLD 10
`define BPO_OPT_PRI_HOLD 11
`define BPO_OPT_WMASK 32'h00000F90
`define BPO_OPT_RESET 32'h00000C00
// ==========================================================
// Status fields
`define BPO_ST_PW_UNDELIV 18
`define BPO_ST_DT_TIMEOUT 23
`define BPO_ST_WMASK 32'h00840000
// ==========================================================
// Counter reset values
`define BPO_RETRY_RESET 32'h01000000
`define BPO_TMO_RESET 16'h8000
`endif

// *** logic/bpo_pkg.sv ***
/*
 Types shared by the bridge option block.
 Assumes the constants header sits beside it.
*/
package bpo_pkg;
   // PCI command codes that the retry matcher compares
   typedef enum logic [3:0]
   {
      BPO_CMD_MEMW = 4'h7,
      BPO_CMD_MWI = 4'hF
   } bpo_cmd_t;
   typedef logic [31:0] bpo_word_t;
endpackage

// *** logic/bpo_counter.sv ***
/*
 Loadable down counter used for retry attempts and master timeouts.
 Assumes one clock, synchronous active-high reset; a load value of zero
 leaves the counter idle.
*/
`timescale 1ns/100ps
module bpo_counter #(parameter int W = 16)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [W-1:0] i_load_val,
   input wire logic i_step,
   input wire logic i_stop,
   output logic o_busy,
   output logic o_expire
);
   logic [W-1:0] cnt_reg; // Remaining steps
   // ==========================================================
   // Count, reload on start
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         cnt_reg <= '0;
         o_busy <= 1'b0;
         o_expire <= 1'b0;
      end
      else
      begin
         o_expire <= 1'b0;
         if (i_load)
         begin
            cnt_reg <= i_load_val;
            o_busy <= (i_load_val != '0);
         end
         else if (i_stop)
            o_busy <= 1'b0;
         else if (i_step && o_busy)
         begin
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == {{(W-1){1'b0}}, 1'b1})
            begin
               o_busy <= 1'b0;
               o_expire <= 1'b1;
            end
         end
      end
   end
   // ==========================================================
   // Checks
   AST_CNT_LOAD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_load && i_load_val != '0) |=> (o_busy && cnt_reg == $past(i_load_val)))
      else $error("Counter did not reload");
endmodule

// *** logic/bpo_top.sv ***
/*
 Port option and timeout control of a two-port bridge, with its AXI4-Lite
 register slave, error status and interrupt. Index 0 is the primary port,
 index 1 the secondary port.
 Assumes one clock standing for the PCI clock, synchronous inputs from the
 bridge core, and an AXI4-Lite master with at most one write and one read
 outstanding.
*/
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "bpo_consts.svh"
module bpo_top import bpo_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // AXI4-Lite slave
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // Retry matching of secondary initiator
   input wire logic [3:0] i_retry_cmd,
   input wire logic [3:0] i_queued_cmd,
   output logic o_retry_match,
   // Per-port core handshakes
   input wire logic [1:0] i_mwi_active,
   input wire logic [1:0] i_line_end,
   output logic [1:0] o_mwi_to_mw,
   output logic [1:0] o_mwi_disconnect,
   input wire logic [1:0] i_req_want,
   input wire logic [1:0] i_frame_asserted,
   input wire logic [1:0] i_fifo_empty,
   input wire logic [1:0] i_target_term,
   output logic [1:0] o_req,
   output logic o_lock_long_req,
   // Posted write delivery attempts
   input wire logic i_pw_start,
   input wire logic i_pw_attempt,
   input wire logic i_pw_done,
   // Delayed transaction repeat watch per port
   input wire logic [1:0] i_dt_start,
   input wire logic [1:0] i_dt_repeat,
   output logic o_primary_system_error_out,
   output logic o_irq
);
   // ==========================================================
   // Registers
   bpo_word_t option_reg; // Port option upper bits
   bpo_word_t retry_limit_reg; // Retry attempt limit
   logic [15:0] pri_tmo_reg; // Primary master timeout
   logic [15:0] sec_tmo_reg; // Secondary master timeout
   bpo_word_t status_reg; // Sticky error status
   bpo_word_t mask_reg; // Interrupt mask
   logic [7:0] aw_addr_reg; // Latched write address
   bpo_word_t w_data_reg; // Latched write data
   logic [3:0] w_strb_reg; // Latched byte enables
   logic aw_have_reg; // Address waiting
   logic w_have_reg; // Data waiting
   logic [7:0] rd_addr_reg; // Address of last read
   bpo_word_t wmask; // Byte enables as bit mask
   logic do_write; // Write committed this cycle
   logic wr_hit; // Write address is mapped
   logic pw_expire; // Retry limit reached
   logic [1:0] dt_expire; // Master timeout expired
   logic [15:0] tmo_val[2]; // Timeout per port
   bpo_word_t st_set; // Hardware status events
   bpo_word_t st_clr; // Software write-one clears
   bpo_word_t rd_val; // Read mux result
   logic rd_hit; // Read address is mapped
   assign do_write = aw_have_reg && w_have_reg && !o_s_axi_bvalid;
   assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
      {8{w_strb_reg[0]}}};
   assign tmo_val[0] = pri_tmo_reg;
   assign tmo_val[1] = sec_tmo_reg;
   // ==========================================================
   // AXI write channels: address and data taken in either order
   assign o_s_axi_awready = !aw_have_reg;
   assign o_s_axi_wready = !w_have_reg;
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (i_s_axi_awvalid && o_s_axi_awready)
         begin
            aw_addr_reg <= i_s_axi_awaddr;
            aw_have_reg <= 1'b1;
         end
         if (i_s_axi_wvalid && o_s_axi_wready)
         begin
            w_data_reg <= i_s_axi_wdata;
            w_strb_reg <= i_s_axi_wstrb;
            w_have_reg <= 1'b1;
         end
         // Response once both halves are in
         if (do_write)
         begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
         end
         else if (o_s_axi_bvalid && i_s_axi_bready)
         begin
            o_s_axi_bvalid <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
         end
      end
   end
   // Decode of mapped write addresses
   always_comb
   begin
      unique case (aw_addr_reg)
         `BPO_OFF_STATUS, `BPO_OFF_OPTION, `BPO_OFF_RETRY, `BPO_OFF_TIMEOUT,
         `BPO_OFF_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end
   // ==========================================================
   // Software-written registers
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         option_reg <= `BPO_OPT_RESET;
         retry_limit_reg <= `BPO_RETRY_RESET;
         pri_tmo_reg <= `BPO_TMO_RESET;
         sec_tmo_reg <= `BPO_TMO_RESET;
         mask_reg <= 32'h00000000;
      end
      else if (do_write)
      begin
         unique case (aw_addr_reg)
            // Reserved option bits never take a write
            `BPO_OFF_OPTION: option_reg <= (option_reg & ~(wmask & `BPO_OPT_WMASK))
               | (w_data_reg & wmask & `BPO_OPT_WMASK);
            `BPO_OFF_RETRY: retry_limit_reg <= (retry_limit_reg & ~wmask)
               | (w_data_reg & wmask);
            `BPO_OFF_TIMEOUT:
            begin
               pri_tmo_reg <= (pri_tmo_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
               sec_tmo_reg <= (sec_tmo_reg & ~wmask[31:16])
                  | (w_data_reg[31:16] & wmask[31:16]);
            end
            `BPO_OFF_MASK: mask_reg <= (mask_reg & ~(wmask & `BPO_ST_WMASK))
               | (w_data_reg & wmask & `BPO_ST_WMASK);
            default:
            begin
               // Status and unmapped addresses leave these untouched
            end
         endcase
      end
   end
   // ==========================================================
   // Sticky status: a set in the clearing cycle wins
   always_comb
   begin
      st_set = 32'h00000000;
      st_set[`BPO_ST_PW_UNDELIV] = pw_expire;
      st_set[`BPO_ST_DT_TIMEOUT] = |dt_expire;
      st_clr = (do_write && aw_addr_reg == `BPO_OFF_STATUS) ?
         (w_data_reg & wmask & `BPO_ST_WMASK) : 32'h00000000;
   end
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         status_reg <= 32'h00000000;
      else
         status_reg <= (status_reg & ~st_clr) | st_set;
   end
   // Error output follows every status bit, interrupt only the unmasked ones
   assign o_primary_system_error_out = |status_reg;
   assign o_irq = |(status_reg & mask_reg);
   // ==========================================================
   // AXI read channel: data one cycle after the address is taken
   assign o_s_axi_arready = !o_s_axi_rvalid;
   always_comb
   begin
      rd_hit = 1'b1;
      unique case (i_s_axi_araddr)
         `BPO_OFF_STATUS: rd_val = status_reg;
         `BPO_OFF_OPTION: rd_val = option_reg & `BPO_OPT_WMASK;
         `BPO_OFF_RETRY: rd_val = retry_limit_reg;
         `BPO_OFF_TIMEOUT: rd_val = {sec_tmo_reg, pri_tmo_reg};
         `BPO_OFF_MASK: rd_val = mask_reg;
         default:
         begin
            rd_val = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h00000000;
         o_s_axi_rresp <= 2'h0;
         rd_addr_reg <= 8'h00;
      end
      else if (i_s_axi_arvalid && o_s_axi_arready)
      begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= rd_val;
         o_s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
         rd_addr_reg <= i_s_axi_araddr;
      end
      else if (i_s_axi_rready)
         o_s_axi_rvalid <= 1'b0;
   end
   // ==========================================================
   // Command policy outputs to the bridge core
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_retry_match <= 1'b0;
         o_lock_long_req <= 1'b0;
      end
      else
      begin
         // Exact match unless MWI may pass for a queued MW
         o_retry_match <= (i_retry_cmd == i_queued_cmd)
            || (option_reg[`BPO_OPT_SEC_MW_ALIAS] && i_retry_cmd == BPO_CMD_MWI
            && i_queued_cmd == BPO_CMD_MEMW);
         o_lock_long_req <= option_reg[`BPO_OPT_LOCK_LONG];
      end
   end
   // ==========================================================
   // Per-port request hold, MWI handling and master timeout
   for (genvar p = 0; p < 2; p++)
   begin : g_port
      logic disc_en; // Line disconnect on MWI
      logic hold_en; // Keep request until drained
      assign disc_en = option_reg[p ? `BPO_OPT_SEC_MWI_DISC : `BPO_OPT_PRI_MWI_DISC];
      assign hold_en = option_reg[p ? `BPO_OPT_SEC_HOLD : `BPO_OPT_PRI_HOLD];
      always_ff @(posedge i_clk_sys)
      begin
         if (i_rst)
         begin
            o_mwi_to_mw[p] <= 1'b0;
            o_mwi_disconnect[p] <= 1'b0;
            o_req[p] <= 1'b0;
         end
         else
         begin
            o_mwi_to_mw[p] <= !disc_en;
            o_mwi_disconnect[p] <= disc_en && i_mwi_active[p] && i_line_end[p];
            if (!o_req[p])
               o_req[p] <= i_req_want[p];
            else if (!hold_en)
               o_req[p] <= !i_frame_asserted[p];
            else if (i_fifo_empty[p] || i_target_term[p])
               o_req[p] <= 1'b0;
         end
      end
      // Counts every clock while waiting for the initiator to repeat
      bpo_counter #(.W(16)) u_tmo
      (
         .i_clk_sys(i_clk_sys),
         .i_rst(i_rst),
         .i_load(i_dt_start[p]),
         .i_load_val(tmo_val[p]),
         .i_step(1'b1),
         .i_stop(i_dt_repeat[p]),
         .o_busy(),
         .o_expire(dt_expire[p])
      );
   end
   // Posted write attempts against the retry limit
   bpo_counter #(.W(32)) u_retry
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_load(i_pw_start),
      .i_load_val(retry_limit_reg),
      .i_step(i_pw_attempt),
      .i_stop(i_pw_done),
      .o_busy(),
      .o_expire(pw_expire)
   );
   // ==========================================================
   // Checks
   AST_RETRY_ALIAS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (option_reg[4] && i_retry_cmd == 4'hF && i_queued_cmd == 4'h7) |=> o_retry_match)
      else $error("MWI retry not aliased");
   AST_PRI_MWI: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (!option_reg[7]) |=> (o_mwi_to_mw[0] && !o_mwi_disconnect[0]))
      else $error("Primary MWI not converted");
   AST_SEC_MWI: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (option_reg[8] && i_mwi_active[1] && i_line_end[1]) |=> o_mwi_disconnect[1])
      else $error("Secondary MWI not disconnected");
   AST_LOCK_LONG: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(option_reg[9]) |=> o_lock_long_req)
      else $error("Long lock request not followed");
   AST_SEC_RELEASE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (o_req[1] && !option_reg[10] && i_frame_asserted[1]) |=> !o_req[1])
      else $error("Secondary request not released");
   AST_PRI_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (o_req[0] && option_reg[11] && !i_fifo_empty[0] && !i_target_term[0]) |=> o_req[0])
      else $error("Primary request dropped early");
   AST_OPT_RSVD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (o_s_axi_rvalid && rd_addr_reg == 8'h74) |-> (o_s_axi_rdata[15:12] == 4'h0
      && o_s_axi_rdata[6:5] == 2'h0))
      else $error("Reserved option bits read nonzero");
   AST_RESET_VAL: assert property (@(posedge i_clk_sys)
      i_rst |=> (retry_limit_reg == 32'h01000000 && pri_tmo_reg == 16'h8000
      && sec_tmo_reg == 16'h8000 && option_reg == 32'h00000C00))
      else $error("Reset values wrong");
   AST_PW_ERR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      pw_expire |=> (status_reg[18] && o_primary_system_error_out))
      else $error("Undelivered posted write not flagged");
   AST_DT_ERR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (|dt_expire) |=> (status_reg[23] && o_primary_system_error_out))
      else $error("Master timeout not flagged");
   CVR_WRITE: cover property (@(posedge i_clk_sys) disable iff (i_rst)
      o_s_axi_bvalid && i_s_axi_bready);
   CVR_TIMEOUT: cover property (@(posedge i_clk_sys) disable iff (i_rst) |dt_expire);
   CVR_IRQ: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_irq));
endmodule

// *** sim/bpo_pci_agent.sv ***
/*
 Far-side PCI agent model for both ports: arbiter grant, frame start, target stop.
 Assumes the clock and synchronous reset of the block under test.
*/
`timescale 1ns/100ps
module bpo_pci_agent
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [1:0] i_req,
   input wire logic [1:0] i_slow,
   input wire logic [1:0] i_abort,
   output logic [1:0] o_frame,
   output logic [1:0] o_term
);
   // Cycles each request has waited for the bus
   logic [2:0] wait_reg [2];
   // ==========================================
   // Grant, then frame, promptly or slowly; frame ends once request drops
   always_ff @(posedge i_clk_sys)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (i_rst || !i_req[p])
         begin
            wait_reg[p] <= 3'h0;
            o_frame[p] <= 1'b0;
         end
         else if (wait_reg[p] >= (i_slow[p] ? 3'h4 : 3'h1))
            o_frame[p] <= 1'b1;
         else
            wait_reg[p] <= wait_reg[p] + 3'h1;
      end
   end
   // Target stops the transfer only while a frame is running
   assign o_term = o_frame & i_abort;
endmodule

// *** sim/bpo_top_tb_top.sv ***
/*
 Self-checking bench of the bridge option and timeout block.
 Assumes the design files and the agent model are compiled first.
*/
`timescale 1ns/100ps
`include "bpo_consts.svh"
`define TB_CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module bpo_top_tb_top import bpo_pkg::*;
;
   // ==========================================
   // Design pins, named as the ports
   logic i_clk_sys, i_rst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
   logic i_s_axi_arvalid, i_s_axi_rready, i_pw_start, i_pw_attempt, i_pw_done;
   logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
   logic [3:0] i_s_axi_wstrb, i_retry_cmd, i_queued_cmd;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
   logic o_retry_match, o_lock_long_req, o_primary_system_error_out, o_irq;
   logic [1:0] i_mwi_active, i_line_end, o_mwi_to_mw, o_mwi_disconnect, i_req_want;
   logic [1:0] i_frame_asserted, i_fifo_empty, i_target_term, o_req, i_dt_start, i_dt_repeat;
   // Agent controls
   logic [1:0] slow, abort;
   int fails, checks_done;
   bpo_top dut (.i_clk_sys, .i_rst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
      .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
      .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
      .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_retry_cmd,
      .i_queued_cmd, .o_retry_match, .i_mwi_active, .i_line_end, .o_mwi_to_mw,
      .o_mwi_disconnect, .i_req_want, .i_frame_asserted, .i_fifo_empty, .i_target_term,
      .o_req, .o_lock_long_req, .i_pw_start, .i_pw_attempt, .i_pw_done, .i_dt_start,
      .i_dt_repeat, .o_primary_system_error_out, .o_irq);
   bpo_pci_agent agent (.i_clk_sys, .i_rst, .i_req(o_req), .i_slow(slow), .i_abort(abort),
      .o_frame(i_frame_asserted), .o_term(i_target_term));
   // ==========================================
   // Shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // A wait that ran out ends the run
   task automatic stall(input string w);
      fails++;
      $display("CHECK FAILED %s expected answer seen timeout", w);
      give_verdict();
   endtask
   // AXI write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge i_clk_sys);
         if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
         if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
         if (o_s_axi_bvalid) break;
      end
      if (n == 40) stall("write response");
      `TB_CHK("write resp", er, o_s_axi_bresp)
      i_s_axi_bready <= 1'b0;
      tick(1);
   endtask
   // AXI read with data and response check
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
      int n;
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge i_clk_sys);
         if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
         if (o_s_axi_rvalid) break;
      end
      if (n == 40) stall("read data");
      `TB_CHK("read data", ex, o_s_axi_rdata)
      `TB_CHK("read resp", er, o_s_axi_rresp)
      i_s_axi_rready <= 1'b0;
      tick(1);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      rd_chk(`BPO_OFF_OPTION, 32'h00000C00, 2'h0);
      rd_chk(`BPO_OFF_RETRY, 32'h01000000, 2'h0);
      rd_chk(`BPO_OFF_TIMEOUT, 32'h80008000, 2'h0);
      rd_chk(`BPO_OFF_STATUS, 32'h00000000, 2'h0);
      `TB_CHK("mwi_to_mw", 2'b11, o_mwi_to_mw)
      `TB_CHK("lock_long", 1'b0, o_lock_long_req)
      $display("Test reset values finished");
   endtask
   task automatic t_regs();
      wr(`BPO_OFF_OPTION, 32'hFFFFFFFF, 2'h0);
      rd_chk(`BPO_OFF_OPTION, 32'h00000F90, 2'h0);
      wr(`BPO_OFF_RETRY, 32'hA5C3F00F, 2'h0);
      rd_chk(`BPO_OFF_RETRY, 32'hA5C3F00F, 2'h0);
      wr(`BPO_OFF_TIMEOUT, 32'h12345678, 2'h0);
      rd_chk(`BPO_OFF_TIMEOUT, 32'h12345678, 2'h0);
      // Byte enables: only the primary half takes this write
      i_s_axi_wstrb <= 4'h3;
      wr(`BPO_OFF_TIMEOUT, 32'hFFFFFFFF, 2'h0);
      i_s_axi_wstrb <= 4'hF;
      rd_chk(`BPO_OFF_TIMEOUT, 32'h1234FFFF, 2'h0);
      wr(8'h90, 32'hFFFFFFFF, 2'h2);
      rd_chk(8'h90, 32'h00000000, 2'h2);
      $display("Test register access finished");
   endtask
   task automatic t_match();
      for (int i = 0; i < 6; i++)
      begin
         wr(`BPO_OFF_OPTION, {27'h0, i[0], 4'h0}, 2'h0);
         i_retry_cmd <= (i == 2 || i == 3) ? BPO_CMD_MEMW : BPO_CMD_MWI;
         i_queued_cmd <= (i < 2) ? BPO_CMD_MEMW : BPO_CMD_MWI;
         tick(2);
         `TB_CHK("retry_match", (i < 2) ? i[0] : (i > 3), o_retry_match)
      end
      $display("Test retry matching finished");
   endtask
   task automatic t_mwi();
      i_mwi_active <= 2'b11;
      i_line_end <= 2'b11;
      for (int i = 0; i < 4; i++)
      begin
         wr(`BPO_OFF_OPTION, {22'h0, i[1], i[1], i[0], 7'h0}, 2'h0);
         tick(2);
         `TB_CHK("mwi_to_mw", ~i[1:0], o_mwi_to_mw)
         `TB_CHK("mwi_disc", i[1:0], o_mwi_disconnect)
         `TB_CHK("lock_long", i[1], o_lock_long_req)
      end
      i_line_end <= 2'b00;
      tick(2);
      `TB_CHK("mwi_disc mid line", 2'b00, o_mwi_disconnect)
      i_mwi_active <= 2'b00;
      $display("Test write-invalidate and lock finished");
   endtask
   task automatic t_hold();
      int n;
      for (int i = 0; i < 4; i++)
      begin
         wr(`BPO_OFF_OPTION, {20'h0, i[1], i[1], 10'h0}, 2'h0);
         slow <= 2'b10;
         i_fifo_empty <= 2'b00;
         i_req_want <= 2'b01 << i[0];
         for (n = 0; n < 10 && o_req !== (2'b01 << i[0]); n++) tick(1);
         if (n == 10) stall("request");
         i_req_want <= 2'b00;
         tick(9);
         `TB_CHK("req after frame", i[1] ? 2'b01 << i[0] : 2'b00, o_req)
         i_fifo_empty <= i[0] ? 2'b00 : 2'b11;
         abort <= i[0] ? 2'b10 : 2'b00;
         tick(2);
         `TB_CHK("req after end", 2'b00, o_req)
         abort <= 2'b00;
      end
      $display("Test request hold finished");
   endtask
   task automatic t_retry();
      wr(`BPO_OFF_MASK, 32'h00040000, 2'h0);
      rd_chk(`BPO_OFF_MASK, 32'h00040000, 2'h0);
      wr(`BPO_OFF_RETRY, 32'h00000003, 2'h0);
      // Two attempts, reload, two more: limit not yet reached
      for (int k = 0; k < 8; k++)
      begin
         i_pw_start <= (k % 4 == 0);
         i_pw_attempt <= k[0];
         tick(1);
      end
      i_pw_start <= 1'b0;
      i_pw_attempt <= 1'b0;
      tick(3);
      `TB_CHK("error before limit", 1'b0, o_primary_system_error_out)
      i_pw_attempt <= 1'b1;
      tick(1);
      i_pw_attempt <= 1'b0;
      tick(4);
      `TB_CHK("error at limit", 1'b1, o_primary_system_error_out)
      `TB_CHK("irq unmasked", 1'b1, o_irq)
      rd_chk(`BPO_OFF_STATUS, 32'h00040000, 2'h0);
      wr(`BPO_OFF_STATUS, 32'h00040000, 2'h0);
      `TB_CHK("error cleared", 1'b0, o_primary_system_error_out)
      `TB_CHK("irq cleared", 1'b0, o_irq)
      // Delivered write stops the count: later attempts never expire it
      i_pw_start <= 1'b1;
      tick(1);
      i_pw_start <= 1'b0;
      i_pw_attempt <= 1'b1;
      i_pw_done <= 1'b1;
      tick(1);
      i_pw_done <= 1'b0;
      tick(4);
      i_pw_attempt <= 1'b0;
      tick(2);
      `TB_CHK("error after done", 1'b0, o_primary_system_error_out)
      $display("Test retry limit finished");
   endtask
   task automatic t_dt();
      int n;
      wr(`BPO_OFF_TIMEOUT, 32'h00060004, 2'h0);
      for (int p = 0; p < 2; p++)
      begin
         n = p ? 6 : 4;
         // Repeated in time: no timeout
         i_dt_start <= 2'b01 << p;
         tick(1);
         i_dt_start <= 2'b00;
         tick(2);
         i_dt_repeat <= 2'b01 << p;
         tick(1);
         i_dt_repeat <= 2'b00;
         tick(n + 4);
         `TB_CHK("error after repeat", 1'b0, o_primary_system_error_out)
         // Restarted late, then left to expire
         for (int s = 0; s < 2; s++)
         begin
            i_dt_start <= 2'b01 << p;
            tick(1);
            i_dt_start <= 2'b00;
            tick(n - 1);
         end
         `TB_CHK("error after reload", 1'b0, o_primary_system_error_out)
         tick(5);
         `TB_CHK("error at timeout", 1'b1, o_primary_system_error_out)
         `TB_CHK("irq masked", 1'b0, o_irq)
         rd_chk(`BPO_OFF_STATUS, 32'h00800000, 2'h0);
         wr(`BPO_OFF_STATUS, 32'h00800000, 2'h0);
      end
      $display("Test master timeout finished");
   endtask
   // ==========================================
   // Clock and main sequence
   initial
   begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   initial
   begin
      fails = 0;
      checks_done = 0;
      i_rst = 1'b1;
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = 4'h0;
      {i_s_axi_rready, i_pw_start, i_pw_attempt, i_pw_done} = 4'h0;
      {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 48'h0;
      i_s_axi_wstrb = 4'hF;
      {i_retry_cmd, i_queued_cmd} = 8'h00;
      {i_mwi_active, i_line_end, i_req_want, i_dt_start, i_dt_repeat} = 10'h000;
      {slow, abort} = 4'h0;
      i_fifo_empty = 2'b11;
      tick(4);
      i_rst <= 1'b0;
      tick(1);
      t_reset();
      t_regs();
      t_match();
      t_mwi();
      t_hold();
      t_retry();
      t_dt();
      give_verdict();
   end
endmodule
